// >>> hdl/qdsc_group.sv
// One converter group: timer sequencer, settle timer and busy flag.
// Assumes a shared 10 us tick and a converter engine that reports transfers in flight.
`timescale 1ns/1ps
`default_nettype none
module qdsc_group
(
    input  wire logic                        clk_sys,     // System clock.
    input  wire logic                        reset_n,     // Asynchronous reset, active low.
    input  wire logic                        tick,        // 10 us time base pulse.
    input  wire qdsc_pkg::qdsc_mode_t        mode,        // Group operating mode.
    input  wire logic                        run_bit,     // Sequencer start/stop.
    input  wire logic [qdsc_pkg::TIMER_W-1:0] preload,    // Timer preload value.
    input  wire logic                        man_update,  // Manual update this cycle.
    input  wire logic                        load_wait,   // Manual load request pending.
    input  wire logic                        xfer_busy,   // Converter transfer in flight.
    output var  logic                        seq_update,  // Timer update pulse.
    output var  logic                        seq_fetch,   // Next data set fetch pulse.
    output var  logic                        busy,        // Group busy flag.
    output var  logic                        settle       // Outputs settling.
);
    import qdsc_pkg::*;

    qdsc_grp_st_t s;
    qdsc_grp_st_t next_s;

    always_comb
    begin
        next_s       = s;
        next_s.upd   = 1'b0;
        next_s.fetch = 1'b0;
        case (s.seq)
            QDSC_SEQ_IDLE:
            begin
                if (run_bit && mode == QDSC_MODE_TIMER)
                begin
                    next_s.seq = QDSC_SEQ_RUN;
                    next_s.cnt = preload;
                end
            end
            QDSC_SEQ_RUN:
            begin
                if (!run_bit || mode != QDSC_MODE_TIMER)
                    next_s.seq = QDSC_SEQ_DRAIN;
                else if (tick)
                begin
                    if (s.cnt == '0)
                    begin
                        next_s.cnt   = preload;
                        next_s.upd   = 1'b1;
                        next_s.fetch = 1'b1;
                    end
                    else
                        next_s.cnt = s.cnt - 24'h000001;
                end
            end
            QDSC_SEQ_DRAIN:
            begin
                // A transfer already started finishes before the sequencer counts as halted.
                if (!xfer_busy)
                    next_s.seq = QDSC_SEQ_IDLE;
            end
            default: next_s.seq = QDSC_SEQ_IDLE;
        endcase
        if (s.upd || man_update)
            next_s.settle_cnt = 16'(SETTLE_CYC);
        else if (s.settle_cnt != 16'h0000)
            next_s.settle_cnt = s.settle_cnt - 16'h0001;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign seq_update = s.upd;
    assign seq_fetch  = s.fetch;
    assign settle     = (s.settle_cnt != 16'h0000);
    assign busy       = (s.seq != QDSC_SEQ_IDLE) || xfer_busy || load_wait;

    property p_settle_holds;
        @(posedge clk_sys) disable iff (!reset_n)
        s.upd |=> settle [*8];
    endproperty
    a_settle_holds: assert property (p_settle_holds) else $error("settle dropped early");

    property p_busy_running;
        @(posedge clk_sys) disable iff (!reset_n)
        (s.seq == QDSC_SEQ_RUN) |-> busy;
    endproperty
    a_busy_running: assert property (p_busy_running) else $error("busy low in run");
endmodule : qdsc_group
`default_nettype wire

// >>> hdl/qdsc_pkg.sv
// Shared constants, register map and carrier types for the converter sequencer control.
// Assumes one 25 MHz system clock and a simple synchronous register port from the host bridge.
package qdsc_pkg;

    localparam int NGRP = 8;

    // Timing: the figures are in nanoseconds; cycle counts round a least time up.
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TICK_TIME_NS   = 10000;
    localparam int SETTLE_TIME_NS = 10000;
    localparam int TICK_CYC       = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_TIMER  = 8'h60;
    localparam logic [7:0] OFS_CLEAR  = 8'h80;
    localparam logic [7:0] OFS_LOAD   = 8'h84;
    localparam logic [7:0] OFS_GCTL   = 8'h88;
    localparam logic [7:0] OFS_GSTAT  = 8'h8c;
    localparam logic [7:0] OFS_ISTAT  = 8'h90;

    // Field positions.
    localparam int STAT_OC_LSB    = 0;
    localparam int STAT_PU_LSB    = 4;
    localparam int STAT_PUREF_BIT = 8;
    localparam int STAT_TSD_BIT   = 9;
    localparam int STAT_SVAL_BIT  = 10;
    localparam int STAT_W         = 11;
    localparam int TIMER_W        = 24;
    localparam int GCTL_MIE_BIT   = 8;
    localparam int GS_BUSY_BIT    = 0;
    localparam int GS_SET_BIT     = 1;
    localparam int GS_SDR_BIT     = 2;
    localparam int GS_SDU_BIT     = 3;
    localparam int IS_AL_LSB      = 0;
    localparam int IS_LD_LSB      = 8;
    localparam int IS_SE_LSB      = 16;

    // Reset values.
    localparam logic [7:0] SDU_RESET = 8'hff;

    typedef enum logic [2:0] {
        QDSC_MODE_INSTANT = 3'b000,
        QDSC_MODE_MANUAL  = 3'b001,
        QDSC_MODE_TIMER   = 3'b011
    } qdsc_mode_t;

    typedef enum logic [1:0] {
        QDSC_SEQ_IDLE  = 2'b00,
        QDSC_SEQ_RUN   = 2'b01,
        QDSC_SEQ_DRAIN = 2'b10
    } qdsc_seq_t;

    // Per-group settings supplied on the grp_cfg input port.
    typedef struct packed {
        qdsc_mode_t mode;
        logic       global_manual;
        logic       irq_seq_en;
        logic       irq_alert_en;
        logic       irq_load_en;
        logic       current_clamp_enable;
    } qdsc_grp_cfg_t;

    // Per-group view of the serial converter engine.
    typedef struct packed {
        logic       xfer_busy;
        logic       data_pending;
        logic       status_strobe;
        logic [9:0] status_word;
    } qdsc_conv_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } qdsc_bus_req_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } qdsc_tick_st_t;

    typedef struct packed {
        qdsc_seq_t          seq;
        logic [TIMER_W-1:0] cnt;
        logic [15:0]        settle_cnt;
        logic               upd;
        logic               fetch;
    } qdsc_grp_st_t;

endpackage : qdsc_pkg

// >>> hdl/qdsc_tick.sv
// Free-running prescaler giving one pulse per 10 us sequencer time base.
// Assumes the 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module qdsc_tick
#(
    parameter int CYC = qdsc_pkg::TICK_CYC
)
(
    input  wire logic clk_sys,  // System clock.
    input  wire logic reset_n,  // Asynchronous reset, active low.
    output var  logic tick      // One-cycle pulse each period.
);
    import qdsc_pkg::*;

    qdsc_tick_st_t s;
    qdsc_tick_st_t next_s;

    always_comb
    begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (s.cnt == 16'(CYC - 1))
        begin
            next_s.cnt  = 16'h0000;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;

endmodule : qdsc_tick
`default_nettype wire

// >>> hdl/qdsc_top.sv
// Register file and event logic for eight converter groups.
// Assumes a synchronous single-cycle register port from the host bridge and a serial engine
// that reports per-group transfer activity and status reads.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Power bits 7:4, clamp off clears on overcurrent
// - Overcurrent flags in status bits 3:0
// - Timer spacing is preload plus one ticks
// - Clear bits drive group clear outputs
// - Load bit recorded only in manual mode
// - Global manual groups update together
// - Load bit self-clears at actual update
// - Master enable gates all interrupts
// - Run bit starts sequencer in timer mode, busy held
// - Stop lets transfer finish, busy until halted
// - Underflow on unacknowledged fetch, resets to one
// - Data request set on sequencer fetch
// - Settle flag high 10 us after update
// - Busy on transfer, load wait, running
// - Global status nibble per group
// - Sequencer interrupt bits 23:16
// - Load interrupt bits 15:8
// - Alert interrupt bits 7:0
// - Interrupt when master enabled and any set
// - Only enabled sources set interrupt bits
module qdsc_top
(
    input  wire logic                                  clk_sys,     // System clock, 25 MHz.
    input  wire logic                                  reset_n,     // Asynchronous reset, low.
    input  wire qdsc_pkg::qdsc_bus_req_t               bus_req,     // Register access request.
    output var  logic [31:0]                           reg_rdata,   // Read data.
    output var  logic                                  reg_rvalid,  // Read data valid pulse.
    input  wire qdsc_pkg::qdsc_grp_cfg_t [7:0]         grp_cfg,     // Per-group settings.
    input  wire qdsc_pkg::qdsc_conv_t [7:0]            conv,        // Converter engine view.
    output var  logic [7:0]                            dac_clear,   // Group clear lines.
    output var  logic [7:0]                            dac_update,  // Output update pulses.
    output var  logic [7:0]                            seq_fetch,   // Data set fetch pulses.
    output var  logic                                  irq_out      // Interrupt, high.
);
    import qdsc_pkg::*;

    typedef struct packed {
        logic [31:0]                     rdata;
        logic                            rvalid;
        logic [NGRP-1:0][STAT_W-1:0]     stat;
        logic [NGRP-1:0][TIMER_W-1:0]    timer;
        logic [NGRP-1:0]                 clr;
        logic [NGRP-1:0]                 load;
        logic                            master_irq_enable;
        logic [NGRP-1:0]                 run;
        logic [NGRP-1:0]                 sdu;
        logic [NGRP-1:0]                 sdr;
        logic [23:0]                     istat;
        logic                            irq;
        logic [NGRP-1:0]                 upd;
        logic [NGRP-1:0]                 fetch;
    } qdsc_top_st_t;

    qdsc_top_st_t s;
    qdsc_top_st_t next_s;

    logic            tick;
    logic [NGRP-1:0] grp_update;
    logic [NGRP-1:0] grp_fetch;
    logic [NGRP-1:0] grp_busy;
    logic [NGRP-1:0] grp_settle;
    logic [NGRP-1:0] manual;
    logic [NGRP-1:0] glm;
    logic [NGRP-1:0] ready;
    logic [NGRP-1:0] man_upd;
    logic            all_glm_ready;

    // True when the address hits a single register.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // True when the address falls in an eight-entry per-group bank.
    function automatic logic bank_hit(input logic [7:0] addr, input logic [7:0] base);
        bank_hit = (addr[7:5] == base[7:5]) && (addr[1:0] == 2'b00);
    endfunction : bank_hit

    qdsc_tick u_tick
    (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (tick)
    );

    genvar g;
    generate
        for (g = 0; g < NGRP; g++)
        begin : g_grp
            assign manual[g] = (grp_cfg[g].mode == QDSC_MODE_MANUAL);
            assign glm[g]    = manual[g] && grp_cfg[g].global_manual;
            assign ready[g]  = s.load[g] && !conv[g].data_pending && !conv[g].xfer_busy;

            qdsc_group u_group
            (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .tick       (tick),
                .mode       (grp_cfg[g].mode),
                .run_bit    (s.run[g]),
                .preload    (s.timer[g]),
                .man_update (man_upd[g]),
                .load_wait  (s.load[g] && manual[g]),
                .xfer_busy  (conv[g].xfer_busy),
                .seq_update (grp_update[g]),
                .seq_fetch  (grp_fetch[g]),
                .busy       (grp_busy[g]),
                .settle     (grp_settle[g])
            );
        end
    endgenerate

    // A global-manual group never fires alone; it waits for every peer to be ready.
    assign all_glm_ready = &(~glm | ready);

    always_comb
    begin
        for (int i = 0; i < NGRP; i++)
            man_upd[i] = manual[i] && ready[i] && (!glm[i] || all_glm_ready);
    end

    always_comb
    begin
        logic       wr;
        logic [7:0] w1c_gs_sdu;
        logic [7:0] w1c_gs_sdr;
        logic [9:0] sw;
        logic [3:0] oc;
        logic [3:0] pu;
        logic [2:0] idx;
        wr         = bus_req.wr;
        w1c_gs_sdu = '0;
        w1c_gs_sdr = '0;
        sw         = '0;
        oc         = '0;
        pu         = '0;
        idx        = bus_req.addr[4:2];
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.upd    = grp_update | man_upd;
        next_s.fetch  = grp_fetch;

        // Software writes; the sdu, sdr and istat flag bits only ever clear on a written one.
        if (wr && bank_hit(bus_req.addr, OFS_TIMER))
            next_s.timer[idx] = bus_req.wdata[TIMER_W-1:0];
        if (wr && hit(bus_req.addr, OFS_CLEAR))
            next_s.clr = bus_req.wdata[NGRP-1:0];
        if (wr && hit(bus_req.addr, OFS_LOAD))
            next_s.load = s.load | (bus_req.wdata[NGRP-1:0] & manual);
        if (wr && hit(bus_req.addr, OFS_GCTL))
        begin
            next_s.master_irq_enable = bus_req.wdata[GCTL_MIE_BIT];
            next_s.run = bus_req.wdata[NGRP-1:0];
        end
        if (wr && hit(bus_req.addr, OFS_GSTAT))
        begin
            for (int i = 0; i < NGRP; i++)
            begin
                w1c_gs_sdu[i] = bus_req.wdata[4*i+GS_SDU_BIT];
                w1c_gs_sdr[i] = bus_req.wdata[4*i+GS_SDR_BIT];
            end
        end
        next_s.sdu = s.sdu & ~w1c_gs_sdu;
        next_s.sdr = s.sdr & ~w1c_gs_sdr;
        if (wr && hit(bus_req.addr, OFS_ISTAT))
            next_s.istat = s.istat & ~bus_req.wdata[23:0];

        // Hardware events come after the clears so that a set in the same cycle wins.
        for (int i = 0; i < NGRP; i++)
        begin
            if (man_upd[i])
            begin
                next_s.load[i] = 1'b0;
                if (grp_cfg[i].irq_load_en)
                    next_s.istat[IS_LD_LSB+i] = 1'b1;
            end
            if (grp_fetch[i])
            begin
                if (s.sdr[i])
                    next_s.sdu[i] = 1'b1;
                next_s.sdr[i] = 1'b1;
                if (grp_cfg[i].irq_seq_en)
                    next_s.istat[IS_SE_LSB+i] = 1'b1;
            end
            if (conv[i].status_strobe)
            begin
                sw = conv[i].status_word;
                oc = sw[STAT_OC_LSB+:4];
                pu = sw[STAT_PU_LSB+:4];
                // Without the clamp an overloaded channel is off even if the word lags.
                if (!grp_cfg[i].current_clamp_enable)
                    pu = pu & ~oc;
                next_s.stat[i] = {1'b1, sw[STAT_TSD_BIT], sw[STAT_PUREF_BIT], pu, oc};
                if (grp_cfg[i].irq_alert_en && (|oc || sw[STAT_TSD_BIT]))
                    next_s.istat[IS_AL_LSB+i] = 1'b1;
            end
        end

        next_s.irq = next_s.master_irq_enable && (|next_s.istat);

        // Reads return one cycle later; unmapped offsets read as zero.
        if (bus_req.rd)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = '0;
            if (bank_hit(bus_req.addr, OFS_STATUS))
                next_s.rdata[STAT_W-1:0] = s.stat[idx];
            else if (bank_hit(bus_req.addr, OFS_TIMER))
                next_s.rdata[TIMER_W-1:0] = s.timer[idx];
            else if (hit(bus_req.addr, OFS_CLEAR))
                next_s.rdata[NGRP-1:0] = s.clr;
            else if (hit(bus_req.addr, OFS_LOAD))
                next_s.rdata[NGRP-1:0] = s.load;
            else if (hit(bus_req.addr, OFS_GCTL))
                next_s.rdata[GCTL_MIE_BIT:0] = {s.master_irq_enable, s.run};
            else if (hit(bus_req.addr, OFS_GSTAT))
            begin
                for (int i = 0; i < NGRP; i++)
                    next_s.rdata[4*i+:4] = {s.sdu[i], s.sdr[i], grp_settle[i], grp_busy[i]};
            end
            else if (hit(bus_req.addr, OFS_ISTAT))
                next_s.rdata[23:0] = s.istat;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s     <= '0;
            s.sdu <= SDU_RESET;
        end
        else
            s <= next_s;
    end

    assign reg_rdata  = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign dac_clear  = s.clr;
    assign dac_update = s.upd;
    assign seq_fetch  = s.fetch;
    assign irq_out    = s.irq;

    property p_clamp_off;
        @(posedge clk_sys) disable iff (!reset_n)
        conv[0].status_strobe && !grp_cfg[0].current_clamp_enable && conv[0].status_word[0]
            |=> !s.stat[0][STAT_PU_LSB];
    endproperty
    a_clamp_off: assert property (p_clamp_off) else $error("power kept on overcurrent");

    property p_oc_capture;
        @(posedge clk_sys) disable iff (!reset_n)
        conv[1].status_strobe |=> s.stat[1][3:0] == $past(conv[1].status_word[3:0]);
    endproperty
    a_oc_capture: assert property (p_oc_capture) else $error("overcurrent bits wrong");

    property p_clear_drive;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_req.wr && bus_req.addr == OFS_CLEAR |=> dac_clear == $past(bus_req.wdata[7:0]);
    endproperty
    a_clear_drive: assert property (p_clear_drive) else $error("clear lines not driven");

    property p_load_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_req.wr && bus_req.addr == OFS_LOAD && !manual[2] && !s.load[2] |=> !s.load[2];
    endproperty
    a_load_ignored: assert property (p_load_ignored) else $error("load taken off manual");

    property p_load_selfclear;
        @(posedge clk_sys) disable iff (!reset_n)
        man_upd[0] && !bus_req.wr |=> !s.load[0] && dac_update[0];
    endproperty
    a_load_selfclear: assert property (p_load_selfclear) else $error("load not cleared");

    property p_global_sync;
        @(posedge clk_sys) disable iff (!reset_n)
        (|(man_upd & glm)) |-> ((man_upd & glm) == glm);
    endproperty
    a_global_sync: assert property (p_global_sync) else $error("global groups split");

    property p_irq_gate;
        @(posedge clk_sys) disable iff (!reset_n)
        irq_out |-> s.master_irq_enable && (|s.istat);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable or source");

    property p_underflow;
        @(posedge clk_sys) disable iff (!reset_n)
        grp_fetch[2] && s.sdr[2] |=> s.sdu[2] && s.sdr[2];
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not flagged");

    property p_seq_irq;
        @(posedge clk_sys) disable iff (!reset_n)
        grp_fetch[2] && grp_cfg[2].irq_seq_en |=> s.istat[IS_SE_LSB+2] && s.sdr[2];
    endproperty
    a_seq_irq: assert property (p_seq_irq) else $error("sequencer irq not set");

    property p_zero_write;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_req.wr && bus_req.addr == OFS_ISTAT && !bus_req.wdata[IS_LD_LSB] && s.istat[IS_LD_LSB]
            |=> s.istat[IS_LD_LSB];
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write cleared");

    property p_fetch_request;
        @(posedge clk_sys) disable iff (!reset_n)
        grp_fetch[2] |=> s.sdr[2] && seq_fetch[2] && dac_update[2];
    endproperty
    a_fetch_request: assert property (p_fetch_request) else $error("no data request");

    property p_alert_gated;
        @(posedge clk_sys) disable iff (!reset_n)
        conv[1].status_strobe && !grp_cfg[1].irq_alert_en && !s.istat[IS_AL_LSB+1]
            |=> !s.istat[IS_AL_LSB+1];
    endproperty
    a_alert_gated: assert property (p_alert_gated) else $error("disabled alert set");

    property p_load_irq;
        @(posedge clk_sys) disable iff (!reset_n)
        man_upd[0] && grp_cfg[0].irq_load_en |=> s.istat[IS_LD_LSB];
    endproperty
    a_load_irq: assert property (p_load_irq) else $error("load irq not set");

    property p_sdu_keep;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_req.wr && bus_req.addr == OFS_GSTAT && !bus_req.wdata[GS_SDU_BIT] && s.sdu[0]
            |=> s.sdu[0];
    endproperty
    a_sdu_keep: assert property (p_sdu_keep) else $error("zero write cleared underflow");

endmodule : qdsc_top
`default_nettype wire

// >>> verif/qdsc_conv_model.sv
// Behavioural stand-in for the serial converter engine and the converter chips behind it.
// Assumes the bench pulses go for one cycle to order a status read of one group.
`timescale 1ns/1ps
`default_nettype none
module qdsc_conv_model
    import qdsc_pkg::*;
(
    input  wire logic                       clk_sys,  // System clock.
    input  wire logic                       go,       // Order a status read.
    input  wire logic [2:0]                 grp,      // Group to read.
    input  wire logic [9:0]                 word,     // Status the chips report.
    output var  qdsc_pkg::qdsc_conv_t [7:0] conv      // Engine view per group.
);
    int         n = 0;
    logic [2:0] g = 3'h0;
    initial conv = '0;
    always @(posedge clk_sys)
    begin
        conv[g].status_strobe <= 1'b0;
        // Outside the strobe the word is not held, so a stale value can never pass.
        conv[g].status_word <= ~word;
        if (go)
        begin
            g = grp;
            n = 20;
            conv[grp].xfer_busy <= 1'b1;
        end
        else if (n > 0)
        begin
            n = n - 1;
            if (n == 0)
            begin
                conv[g].xfer_busy     <= 1'b0;
                conv[g].status_strobe <= 1'b1;
                conv[g].status_word   <= word;
            end
        end
    end
endmodule : qdsc_conv_model
`default_nettype wire

// >>> verif/quad_dac_sequencer_control_test.sv
// Self-checking bench for the converter sequencer control block.
// Assumes the converter model stands in for the serial engine and chips.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_sequencer_control_test;
    import qdsc_pkg::*;
    logic                clk_sys, reset_n, go, reg_rvalid, irq_out;
    logic [2:0]          grp;
    logic [9:0]          word;
    logic [7:0]          dac_clear, dac_update, seq_fetch, v;
    logic [31:0]         reg_rdata, seed;
    qdsc_bus_req_t       bus_req;
    qdsc_grp_cfg_t [7:0] grp_cfg;
    qdsc_conv_t [7:0]    conv;
    int                  miscompares, num_checks;
    time                 t0;
    qdsc_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .grp_cfg(grp_cfg), .conv(conv),
        .dac_clear(dac_clear), .dac_update(dac_update), .seq_fetch(seq_fetch),
        .irq_out(irq_out));
    qdsc_conv_model u_conv (.clk_sys(clk_sys), .go(go), .grp(grp), .word(word), .conv(conv));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys) bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys) bus_req.wr = 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk_sys) bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge clk_sys) chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, e);
        bus_req.rd = 1'b0;
    endtask : bus_rd
    task automatic wait_ev(input int g, input bit f);
        int i;
        for (i = 0; i < 1200 && (f ? seq_fetch[g] : dac_update[g]) !== 1'b1; i++)
            @(negedge clk_sys);
        if (i == 1200)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask : wait_ev
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        {reset_n, go, grp, word, bus_req, miscompares, num_checks} = '0;
        seed       = 32'd62437;
        grp_cfg    = '0;
        grp_cfg[0] = '{QDSC_MODE_MANUAL, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        grp_cfg[1] = '{QDSC_MODE_INSTANT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        grp_cfg[2] = '{QDSC_MODE_TIMER, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        grp_cfg[3] = '{QDSC_MODE_MANUAL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        grp_cfg[4] = grp_cfg[3];
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) reset_n = 1'b1;
        bus_rd(OFS_GSTAT, 32'h88888888);
        bus_rd(OFS_ISTAT, 32'h0);
        bus_rd(8'hfc, 32'h0);
        repeat (3)
        begin
            v = 8'(xs());
            bus_wr(OFS_CLEAR, {24'hffffff, v});
            bus_rd(OFS_CLEAR, {24'h0, v});
            chk({24'h0, dac_clear}, {24'h0, v});
        end
        bus_wr(OFS_CLEAR, 32'h0);
        bus_wr(OFS_GCTL, 32'h100);
        bus_wr(OFS_LOAD, 32'h05);
        wait_ev(0, 1'b0);
        bus_rd(OFS_LOAD, 32'h0);
        bus_rd(OFS_ISTAT, 32'h100);
        chk({31'h0, irq_out}, 32'h1);
        bus_rd(OFS_GSTAT, 32'h8888888a);
        repeat (SETTLE_CYC + 10) @(negedge clk_sys);
        bus_rd(OFS_GSTAT, 32'h88888888);
        bus_wr(OFS_ISTAT, 32'h0);
        bus_rd(OFS_ISTAT, 32'h100);
        bus_wr(OFS_GCTL, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        bus_wr(OFS_ISTAT, 32'h100);
        @(negedge clk_sys) {go, grp, word} = {1'b1, 3'd1, 10'h1f1};
        @(negedge clk_sys) go = 1'b0;
        repeat (30) @(negedge clk_sys);
        @(negedge clk_sys) {go, grp} = {1'b1, 3'd0};
        @(negedge clk_sys) go = 1'b0;
        bus_rd(OFS_GSTAT, 32'h88888889);
        repeat (30) @(negedge clk_sys);
        bus_rd(OFS_STATUS, 32'h5e1);
        bus_rd(OFS_STATUS + 8'h4, 32'h5f1);
        bus_rd(OFS_ISTAT, 32'h1);
        // Timer first, then start; the mode was set in grp_cfg before reset.
        bus_wr(OFS_TIMER + 8'h8, 32'h1);
        bus_wr(OFS_GCTL, 32'h4);
        wait_ev(2, 1'b1);
        t0 = $time;
        bus_rd(OFS_GSTAT, 32'h88888f88);
        bus_wr(OFS_GSTAT, 32'hc00);
        bus_rd(OFS_GSTAT, 32'h88888388);
        wait_ev(2, 1'b1);
        chk(32'(($time - t0) / CLK_PERIOD_NS), 32'(2 * TICK_CYC));
        bus_rd(OFS_GSTAT, 32'h88888788);
        wait_ev(2, 1'b1);
        bus_rd(OFS_GSTAT, 32'h88888f88);
        bus_rd(OFS_ISTAT, 32'h40001);
        // A status read is in flight when the sequencer is stopped.
        @(negedge clk_sys) {go, grp} = {1'b1, 3'd2};
        @(negedge clk_sys) go = 1'b0;
        bus_wr(OFS_GCTL, 32'h100);
        chk({31'h0, irq_out}, 32'h1);
        bus_rd(OFS_GSTAT, 32'h88888f88);
        repeat (SETTLE_CYC + 50) @(negedge clk_sys);
        bus_rd(OFS_GSTAT, 32'h88888c88);
        bus_wr(OFS_LOAD, 32'h08);
        bus_rd(OFS_GSTAT, 32'h88889c88);
        bus_wr(OFS_LOAD, 32'h10);
        wait_ev(3, 1'b0);
        chk({24'h0, dac_update}, 32'h18);
        report_and_stop();
    end
endmodule : quad_dac_sequencer_control_test
`default_nettype wire
